// ==== src/pom_pkg.sv ====
/*
 * Constants, register map and carrier types of the position output mode logic.
 * Assumes one 50 MHz clock, a classic Wishbone master with 32-bit data,
 * and an interpolator core that supplies step, direction and test signals
 * on the same clock.
 */
// Functional notes
// - Commutation mode: ABZ on P pins, UVW on N
// - Counter mode: down, up, combined clocks on PA/NA/PB
// - Counter mode NB: low up, high down
// - Counter mode PZ high at index position
// - Counter mode NZ low at index position
// - Test mode edges every 90/45 degrees
// - Test mode: A8/B8 on PA/PB, A4/B4 on NA/NB
// - Test mode PZ carries raw unmasked index
// - Test mode NZ low while line check runs
// - Check error valid after second enabled index
// - Drivers enabled only in three output modes
// - Mode field selects every pin function
package pom_pkg;

    // ------------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------------
    localparam logic [3:0] POM_MODE_QUAD    = 4'h0;   // Quadrature with index
    localparam logic [3:0] POM_MODE_SYSTEST = 4'hb;   // Digital system test
    localparam logic [3:0] POM_MODE_COMMUT  = 4'he;   // Quadrature plus commutation
    localparam logic [3:0] POM_MODE_COUNTER = 4'hf;   // Up/down counter control
    localparam logic [3:0] POM_MODE_RESET   = 4'h0;   // Mode after reset

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] POM_REG_CTRL   = 8'h00;    // Mode field
    localparam logic [7:0] POM_REG_LINES  = 8'h04;    // Expected steps per index
    localparam logic [7:0] POM_REG_IRQST  = 8'h08;    // Sticky events, write one clears
    localparam logic [7:0] POM_REG_IRQMSK = 8'h0c;    // Event mask, same layout
    localparam logic [7:0] POM_REG_STATE  = 8'h10;    // Live block state

    // ------------------------------------------------------------------
    // Field layout and widths
    // ------------------------------------------------------------------
    localparam int         POM_LINES_W      = 16;     // Line counter width
    localparam logic [15:0] POM_LINES_RESET = 16'h0000;
    localparam int         POM_EV_INDEX     = 0;      // Enabled index seen
    localparam int         POM_EV_DONE      = 1;      // Line check finished
    localparam int         POM_EV_ERR       = 2;      // Line check mismatch
    localparam int         POM_EV_W         = 3;      // Number of events

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int POM_CLK_MHZ     = 50;              // Core clock rate
    localparam int POM_PULSE_NS    = 40;              // Least low time of a count clock
    localparam int POM_PULSE_CYC_I = (POM_PULSE_NS * POM_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] POM_PULSE_CYC = 4'(POM_PULSE_CYC_I);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic pa;
        logic na;
        logic pb;
        logic nb;
        logic pz;
        logic nz;
    } pom_pins_type;

    typedef struct packed {
        logic a4;       // Resolution 4 channel A
        logic b4;       // Resolution 4 channel B
        logic a8;       // Resolution 8 channel A
        logic b8;       // Resolution 8 channel B
    } pom_test_type;

endpackage : pom_pkg

// ==== src/pom_output_mode.sv ====
/*
 * Output mode logic: maps interpolator signals onto the six output pins
 * by mode, generates up/down counter clocks, runs the line count check
 * and offers registers over classic Wishbone with an event interrupt.
 * Assumes step, direction, quadrature, commutation and index signals come
 * from logic on clk_i; the index enable arrives from a pin.
 */
// The register offsets and the Wishbone slave port were chosen for this implementation.
module pom_output_mode
    import pom_pkg::*;
(
    input  wire logic                clk_i,          // 50 MHz core clock
    input  wire logic                rst_i,          // Synchronous, active high
    // Wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Interpolator side, same clock
    input  wire logic                step_i,         // One-cycle pulse per angle step
    input  wire logic                step_down_i,    // Direction of that step, 1 = down
    input  wire logic                quad_a_i,
    input  wire logic                quad_b_i,
    input  wire logic                quad_z_i,       // Gated index
    input  wire logic                comm_u_i,
    input  wire logic                comm_v_i,
    input  wire logic                comm_w_i,
    input  wire logic                raw_index_i,    // Index before gating
    input  wire pom_pkg::pom_test_type test_i,       // Resolution 4/8 test edges
    input  wire logic                index_enable_i, // Index enable pin, asynchronous
    // Pins
    output pom_pkg::pom_pins_type    pins_o,
    output logic                     pins_oe_o,      // Line drivers active
    output logic                     err_o,          // Check error, valid only when set
    output logic                     irq_o
);

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        POM_CHK_WAIT  = 3'b001,   // Waiting for first enabled index
        POM_CHK_COUNT = 3'b010,   // Counting steps up to second index
        POM_CHK_DONE  = 3'b100    // Result stands until reset
    } pom_chk_type;

    logic [3:0]             mode_q;                 // Selected mode
    logic [POM_LINES_W-1:0] lines_q;                // Expected steps per index
    logic [POM_EV_W-1:0]    irq_st_q;               // Sticky events
    logic [POM_EV_W-1:0]    irq_msk_q;              // Event enables
    logic [31:0]            dat_q;                  // Read data
    logic                   ack_q;                  // Bus answer
    logic [2:0]             en_sync_q;              // Pin synchroniser
    logic                   en_q;                   // Filtered enable
    logic                   idx_prev_q;             // Raw index last cycle
    pom_chk_type            chk_q;                  // Line check state
    pom_chk_type            chk_d;
    logic [POM_LINES_W-1:0] cnt_q;                  // Steps since first index
    logic                   chk_err_q;              // Mismatch found
    logic                   dir_q;                  // Direction held for the counter
    logic                   pend_q;                 // Step waiting one cycle for dir
    logic [3:0]             pulse_q;                // Remaining low cycles
    logic                   pulse_dn_q;             // Direction of pulse in flight
    pom_pins_type           pins_q;
    pom_pins_type           pins_d;
    logic                   oe_q;
    logic                   err_q;
    logic                   irq_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    wire        bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;  // Lands at the ack edge
    wire        hit_ctrl  = wb_adr_i == POM_REG_CTRL;
    wire        hit_lines = wb_adr_i == POM_REG_LINES;
    wire        hit_irqst = wb_adr_i == POM_REG_IRQST;
    wire        hit_msk   = wb_adr_i == POM_REG_IRQMSK;
    wire        hit_state = wb_adr_i == POM_REG_STATE;
    wire        wr_lane0  = bus_wr & wb_sel_i[0];
    wire        wr_lane1  = bus_wr & wb_sel_i[1];

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    wire        m_quad    = mode_q == POM_MODE_QUAD;
    wire        m_comm    = mode_q == POM_MODE_COMMUT;
    wire        m_cnt     = mode_q == POM_MODE_COUNTER;
    wire        m_test    = mode_q == POM_MODE_SYSTEST;
    wire        drv_en    = m_quad | m_comm | m_cnt;

    // ------------------------------------------------------------------
    // Index edge and line check events
    // ------------------------------------------------------------------
    wire        idx_rise  = raw_index_i & ~idx_prev_q;
    wire        idx_ev    = idx_rise & en_q;                    // Enabled index only
    wire        chk_end   = (chk_q == POM_CHK_COUNT) & idx_ev;
    wire        cnt_match = cnt_q == lines_q;
    wire [POM_EV_W-1:0] ev_set = {chk_end & ~cnt_match, chk_end, idx_ev};

    // ------------------------------------------------------------------
    // Counter clock pulse
    // ------------------------------------------------------------------
    wire        pulse_on  = pulse_q != 4'h0;

    // Read data selection, unmapped addresses read zero
    wire [31:0] rd_data =
        hit_ctrl  ? {28'h0000000, mode_q} :
        hit_lines ? {16'h0000, lines_q} :
        hit_irqst ? {29'h0, irq_st_q} :
        hit_msk   ? {29'h0, irq_msk_q} :
        hit_state ? {16'h0000, cnt_q[14:0], 1'b0} |
                    {27'h0, chk_q == POM_CHK_COUNT, chk_q == POM_CHK_DONE,
                     chk_err_q, dir_q, drv_en} :
                    32'h00000000;

    // ------------------------------------------------------------------
    // Wishbone answer: one cycle after the request, dropped the next
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            dat_q <= bus_req ? rd_data : dat_q;
        end
    end

    // Configuration registers, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q    <= POM_MODE_RESET;
            lines_q   <= POM_LINES_RESET;
            irq_msk_q <= '0;
        end else begin
            if (wr_lane0 & hit_ctrl) begin
                mode_q <= wb_dat_i[3:0];
            end
            if (wr_lane0 & hit_lines) begin
                lines_q[7:0] <= wb_dat_i[7:0];
            end
            if (wr_lane1 & hit_lines) begin
                lines_q[15:8] <= wb_dat_i[15:8];
            end
            if (wr_lane0 & hit_msk) begin
                irq_msk_q <= wb_dat_i[POM_EV_W-1:0];
            end
        end
    end

    // Sticky events: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~((wr_lane0 & hit_irqst) ?
                         wb_dat_i[POM_EV_W-1:0] : {POM_EV_W{1'b0}})) | ev_set;
            irq_q    <= |(irq_st_q & irq_msk_q);
        end
    end

    // ------------------------------------------------------------------
    // Index enable pin: three flip-flops, accept when last two agree
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_sync_q <= 3'b000;
            en_q      <= 1'b0;
        end else begin
            en_sync_q <= {en_sync_q[1:0], index_enable_i};
            en_q      <= (en_sync_q[2] == en_sync_q[1]) ? en_sync_q[2] : en_q;
        end
    end

    // ------------------------------------------------------------------
    // Line count check between two enabled index pulses
    // ------------------------------------------------------------------
    always_comb begin
        chk_d = chk_q;
        unique case (chk_q)
            POM_CHK_WAIT:  chk_d = idx_ev ? POM_CHK_COUNT : POM_CHK_WAIT;
            POM_CHK_COUNT: chk_d = idx_ev ? POM_CHK_DONE : POM_CHK_COUNT;
            POM_CHK_DONE:  chk_d = POM_CHK_DONE;                // Restarts only on reset
            default:       chk_d = POM_CHK_WAIT;
        endcase
    end

    // Check state, step count and verdict
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_q      <= POM_CHK_WAIT;
            cnt_q      <= '0;
            chk_err_q  <= 1'b0;
            idx_prev_q <= 1'b0;
        end else begin
            chk_q      <= chk_d;
            idx_prev_q <= raw_index_i;
            if (chk_q == POM_CHK_WAIT) begin
                cnt_q <= '0;
            end else if (chk_q == POM_CHK_COUNT && step_i) begin
                cnt_q <= cnt_q + 1'b1;
            end
            if (chk_end) begin
                chk_err_q <= ~cnt_match;
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter clocks: direction first, low pulse one cycle later
    // ------------------------------------------------------------------
    // A step during a pulse still in flight restarts the pulse; the minimum
    // edge distance upstream is what keeps steps apart.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q      <= 1'b0;
            pend_q     <= 1'b0;
            pulse_q    <= 4'h0;
            pulse_dn_q <= 1'b0;
        end else begin
            pend_q <= step_i;
            if (step_i) begin
                dir_q <= step_down_i;
            end
            if (pend_q) begin
                pulse_q    <= POM_PULSE_CYC;
                pulse_dn_q <= dir_q;
            end else if (pulse_on) begin
                pulse_q <= pulse_q - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin function by mode
    // ------------------------------------------------------------------
    always_comb begin
        pins_d = '0;
        if (m_comm) begin
            pins_d = '{pa: quad_a_i, na: comm_u_i, pb: quad_b_i,
                       nb: comm_v_i, pz: quad_z_i, nz: comm_w_i};
        end else if (m_cnt) begin
            pins_d.pa = ~(pulse_on & pulse_dn_q);
            pins_d.na = ~(pulse_on & ~pulse_dn_q);
            pins_d.pb = ~pulse_on;
            pins_d.nb = dir_q;
            pins_d.pz = quad_z_i;
            pins_d.nz = ~quad_z_i;
        end else if (m_test) begin
            pins_d = '{pa: test_i.a8, na: test_i.a4, pb: test_i.b8,
                       nb: test_i.b4, pz: raw_index_i,
                       nz: chk_q == POM_CHK_DONE};
        end else if (m_quad) begin
            pins_d = '{pa: quad_a_i, na: ~quad_a_i, pb: quad_b_i,
                       nb: ~quad_b_i, pz: quad_z_i, nz: ~quad_z_i};
        end
    end

    // Output flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_q <= '0;
            oe_q   <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            pins_q <= pins_d;
            oe_q   <= drv_en;
            err_q  <= (chk_q == POM_CHK_DONE) & chk_err_q;
        end
    end

    assign pins_o    = pins_q;
    assign pins_oe_o = oe_q;
    assign err_o     = err_q;
    assign irq_o     = irq_q;
    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = dat_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking pom_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DRV_MODES: assert property (
        pins_oe_o |-> $past(m_quad | m_comm | m_cnt))
        else $error("Drivers active outside output modes");

    AST_COMM_MAP: assert property (
        m_comm && $stable(mode_q) |=> pins_o.na == $past(comm_u_i)
                                       && pins_o.pa == $past(quad_a_i))
        else $error("Commutation pin map wrong");

    AST_CNT_PULSE: assert property (
        m_cnt && step_i ##1 m_cnt [*2] |=>
            !pins_o.pb)
        else $error("Combined clock missed a step");

    AST_DIR_FIRST: assert property (
        m_cnt && $fell(pins_o.pb) |-> $stable(pins_o.nb))
        else $error("Direction changed with count clock edge");

    AST_UPDN: assert property (
        !(pins_o.pa == 1'b0 && pins_o.na == 1'b0) || !$past(m_cnt))
        else $error("Up and down clocks both low");

    AST_DIR_LEVEL: assert property (
        m_cnt && $past(m_cnt) && !pins_o.na |-> pins_o.nb == 1'b0)
        else $error("Up pulse with down direction");

    AST_CNT_INDEX: assert property (
        $past(m_cnt) |-> pins_o.pz == $past(quad_z_i) && pins_o.nz == !$past(quad_z_i))
        else $error("Counter reset or load pin wrong");

    AST_TEST_NZ: assert property (
        m_test && chk_q != POM_CHK_DONE |=> !pins_o.nz)
        else $error("Check pin high while check runs");

    AST_TEST_MAP: assert property (
        $past(m_test) |-> pins_o.pa == $past(test_i.a8) && pins_o.nb == $past(test_i.b4)
                          && pins_o.pz == $past(raw_index_i))
        else $error("System test pin map wrong");

    AST_ERR_VALID: assert property (
        err_o |-> $past(chk_q == POM_CHK_DONE))
        else $error("Error reported before second index");

    AST_ACK_ONE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle");

    COV_COUNT_DOWN: cover property (m_cnt ##1 step_i && step_down_i ##[1:4] !pins_o.pa);
    COV_CHECK_DONE: cover property (chk_q == POM_CHK_COUNT ##1 chk_q == POM_CHK_DONE);
    COV_CHECK_ERR:  cover property (err_o && irq_o);

endmodule : pom_output_mode

// ==== tb/pom_counter_model.sv ====
/*
 * Model of an external up/down counter fed by the six output pins.
 * Assumes the counter control pin mapping, with count clocks idling high.
 */
module pom_counter_model
    import pom_pkg::*;
#(
    parameter logic [15:0] LOAD_VALUE = 16'h0000  // Parallel load word
)
(
    input  wire pom_pkg::pom_pins_type pins_i,       // Pin levels from the block
    output logic [15:0]                comb_count_o, // Combined clock plus direction
    output logic [15:0]                ud_count_o    // Separate up and down clocks
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Pin roles
    // ------------------------------------------------------------------
    wire logic   comb_clk_w = pins_i.pb;  // Combined count clock
    wire logic   down_clk_w = pins_i.pa;  // Down count clock
    wire logic   up_clk_w   = pins_i.na;  // Up count clock
    wire logic   clear_w    = pins_i.pz;  // Asynchronous clear, active high
    wire logic   load_n_w   = pins_i.nz;  // Asynchronous load, active low
    logic [15:0] up_q;                    // Rising edges of the up clock
    logic [15:0] down_q;                  // Rising edges of the down clock
    // Counting happens as the low pulse ends, like a real counter part
    always @(posedge comb_clk_w or posedge clear_w or negedge load_n_w) begin
        if (clear_w) begin
            comb_count_o <= 16'h0000;
        end else if (!load_n_w) begin
            comb_count_o <= LOAD_VALUE;
        end else if (pins_i.nb) begin
            comb_count_o <= comb_count_o - 16'h0001;
        end else begin
            comb_count_o <= comb_count_o + 16'h0001;
        end
    end
    // Up and down clocks kept apart, so a pulse on the wrong pin shows
    always @(posedge up_clk_w or posedge clear_w or negedge load_n_w) begin
        if (clear_w || !load_n_w) up_q <= 16'h0000;
        else up_q <= up_q + 16'h0001;
    end
    always @(posedge down_clk_w or posedge clear_w or negedge load_n_w) begin
        if (clear_w || !load_n_w) down_q <= 16'h0000;
        else down_q <= down_q + 16'h0001;
    end
    assign ud_count_o = LOAD_VALUE + up_q - down_q;
endmodule : pom_counter_model

// ==== tb/position_output_mode_logic_test.sv ====
/*
 * Bench of the output mode logic: pin tables, counter steps, line check, events.
 * Assumes the package and the counter model are compiled before it.
 */
module position_output_mode_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pom_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  mode;  // Mode code
        logic [10:0] stim;  // a,b,z,u,v,w,raw index,test a4,b4,a8,b8
        logic [6:0]  want;  // Pins pa..nz then driver enable
    } pom_row_type;
    pom_row_type  rows [11] = '{'{4'h0, 11'h500, 7'h4d}, '{4'h0, 11'h300, 7'h35},
        '{4'he, 11'h460, 7'h4b}, '{4'he, 11'h380, 7'h35}, '{4'hf, 11'h100, 7'h75},
        '{4'hf, 11'h000, 7'h73}, '{4'hb, 11'h019, 7'h34}, '{4'hb, 11'h006, 7'h48},
        '{4'h1, 11'h7ff, 7'h00}, '{4'h6, 11'h7ff, 7'h00}, '{4'hd, 11'h7ff, 7'h00}};
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, step_i = 1'b0, step_down_i = 1'b0;
    logic         index_enable_i = 1'b0;       // Kept low until the line check runs
    logic [7:0]   adr = 8'h00;
    logic [31:0]  wdat = 32'h0, rdat, wb_dat_o;
    logic [10:0]  stim_q = 11'h000;            // Level inputs, packed as in a row
    logic         wb_ack_o, pins_oe_o, err_o, irq_o;
    pom_pins_type pins_o;
    wire   [31:0] pin_word = {25'h0, pins_o, pins_oe_o};  // Pins pa..nz and enable
    logic [15:0]  comb_count, ud_count;
    int           num_errors = 0, tests_run = 0;
    always #10 clk_i = ~clk_i;                 // 50 MHz
    pom_output_mode i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .step_i(step_i), .step_down_i(step_down_i),
        .quad_a_i(stim_q[10]), .quad_b_i(stim_q[9]), .quad_z_i(stim_q[8]),
        .comm_u_i(stim_q[7]), .comm_v_i(stim_q[6]), .comm_w_i(stim_q[5]),
        .raw_index_i(stim_q[4]), .test_i(pom_test_type'(stim_q[3:0])),
        .index_enable_i(index_enable_i), .pins_o(pins_o), .pins_oe_o(pins_oe_o),
        .err_o(err_o), .irq_o(irq_o));
    pom_counter_model i_counter (.pins_i(pins_o), .comb_count_o(comb_count),
        .ud_count_o(ud_count));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    // One classic cycle; waits for ack under a bound, data taken at that edge
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o;
        if (wb_ack_o !== 1'b1) num_errors++;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb_xfer
    // Counter step; spacing stays above the four cycles a pulse needs
    task automatic do_step(input logic down);
        @(posedge clk_i);
        step_i <= 1'b1; step_down_i <= down;
        @(posedge clk_i);
        step_i <= 1'b0;
        @(posedge clk_i);
        #1 check({31'h0, pins_o.nb}, {31'h0, down});
        check({31'h0, pins_o.pb}, 32'h1);
        @(posedge clk_i);
        #1 check({28'h0, pins_o[5:2]}, {28'h0, !down, down, 1'b0, down});
        repeat (2) @(posedge clk_i);
        #1 check({29'h0, pins_o.pa, pins_o.na, pins_o.pb}, 32'h7);
    endtask : do_step
    // One-cycle step pulse or level pattern, then a quiet gap
    task automatic tick(input logic s, input logic [10:0] v);
        @(posedge clk_i);
        step_i <= s; stim_q <= v;
        @(posedge clk_i);
        step_i <= 1'b0; stim_q <= 11'h000;
        repeat (4) @(posedge clk_i);
    endtask : tick
    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 check({22'h0, pins_o, pins_oe_o, err_o, irq_o, wb_ack_o}, 32'h0);
    endtask : do_reset
    // Line check between two enabled index edges with a given step count
    task automatic run_check(input logic [15:0] lines, input int steps);
        wb_xfer(1'b1, POM_REG_LINES, {16'h0, lines}, rdat);
        wb_xfer(1'b1, POM_REG_IRQMSK, 32'h7, rdat);
        wb_xfer(1'b1, POM_REG_CTRL, {28'h0, POM_MODE_SYSTEST}, rdat);
        index_enable_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        tick(1'b0, 11'h010);
        repeat (steps) tick(1'b1, 11'h000);
        #1 check({30'h0, pins_o.nz, err_o}, 32'h0);
        tick(1'b0, 11'h010);
        #1 check({30'h0, pins_o.nz, err_o}, {30'h0, 1'b1, steps != int'(lines)});
    endtask : run_check
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, POM_REG_CTRL, 32'h0, rdat);
        check(rdat, {28'h0, POM_MODE_RESET});
        wb_xfer(1'b0, 8'h14, 32'h0, rdat);
        check(rdat, 32'h0);
        foreach (rows[i]) begin
            wb_xfer(1'b1, POM_REG_CTRL, {28'h0, rows[i].mode}, rdat);
            stim_q <= rows[i].stim;
            repeat (3) @(posedge clk_i);
            #1 check(pin_word, {25'h0, rows[i].want});
        end
        wb_xfer(1'b1, POM_REG_CTRL, {28'h0, POM_MODE_COUNTER}, rdat);
        tick(1'b0, 11'h100);
        do_step(1'b1);
        do_step(1'b1);
        do_step(1'b0);
        check({16'h0, comb_count}, 32'hffff);
        check({16'h0, ud_count}, 32'hffff);
        run_check(16'h0003, 3);
        wb_xfer(1'b0, POM_REG_IRQST, 32'h0, rdat);
        check({28'h0, rdat[2:0], irq_o}, 32'h7);
        wb_xfer(1'b1, POM_REG_IRQST, 32'h7, rdat);
        wb_xfer(1'b0, POM_REG_IRQST, 32'h0, rdat);
        check({28'h0, rdat[2:0], irq_o}, 32'h0);
        do_reset();
        run_check(16'h0002, 3);
        wb_xfer(1'b0, POM_REG_IRQST, 32'h0, rdat);
        check(rdat, 32'h7);
        wb_xfer(1'b1, POM_REG_IRQMSK, 32'h0, rdat);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wb_xfer(1'b1, POM_REG_IRQMSK, 32'h4, rdat);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        test_done();
    end
endmodule : position_output_mode_logic_test
